// >>> pwo_cfg.svh
// Register indices, byte addresses, field positions and masks of the output stage block.
// Assumes it is included by bare name from the top module and the testbench.
`ifndef PWO_CFG_SVH
`define PWO_CFG_SVH

// Register indices; the bus byte address is four times the index
`define PWO_IDX_RATE_BRIDGE 8'h31
`define PWO_IDX_MIN_PULSE 8'h32
`define PWO_IDX_OUT_DELAY 8'h33
`define PWO_IDX_STATUS 8'h38
`define PWO_ADDR_W 12
`define PWO_ADDR_OF(idx) ({2'h0, idx, 2'h0})

// Rate and bridge register fields
`define PWO_BIT_DOUBLE_RATE 7
`define PWO_BIT_PAIR1 4
`define PWO_BIT_PAIR2 3
`define PWO_BIT_A3 2
`define PWO_BIT_B3 1
`define PWO_MASK_RATE_BRIDGE 8'h9E

// Minimum pulse register fields
`define PWO_BIT_MINUS_OFF 7
`define PWO_MIN_LSB 0
`define PWO_MIN_MSB 4
`define PWO_MASK_MIN_PULSE 8'h9F

// Output delay register fields (only the channel skew bits are kept)
`define PWO_SKEW_LSB 5
`define PWO_SKEW_MSB 7
`define PWO_MASK_OUT_DELAY 8'hE0

// Status register fields
`define PWO_BIT_ST_POWERDOWN 0
`define PWO_BIT_ST_REJECTED 1
`define PWO_BIT_ST_PENDING 2

// Reset values and bus constants
`define PWO_RESET_BYTE 8'h00
`define PWO_RESET_WORD 32'h0000_0000
`define PWO_HTRANS_ACTIVE_BIT 1
`define PWO_HRESP_OKAY 1'h0

`endif

// >>> pwo_pkg.sv
// Types shared by the output stage modules.
// Assumes pwo_cfg.svh is reachable on the include path.
package pwo_pkg;

  // Register selected by the captured address phase
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_RATE_BRIDGE,
    SEL_MIN_PULSE,
    SEL_OUT_DELAY,
    SEL_STATUS
  } pwo_sel_t;

  // Whole state of the top module
  typedef struct packed {
    logic [7:0] shadowCfg;
    logic [7:0] shadowMin;
    logic [7:0] shadowDly;
    logic [7:0] activeCfg;
    logic [7:0] activeMin;
    logic [7:0] activeDly;
    logic phWrite;
    pwo_sel_t phSel;
    logic rejected;
    logic [31:0] rdata;
    logic [5:0] outPlus;
    logic [5:0] outMinus;
  } pwo_top_state_t;

  // State of one minimum pulse stage
  typedef struct packed {
    logic level;
    logic [4:0] held;
  } pwo_min_state_t;

  // State of one skew delay line
  typedef struct packed {
    logic [6:0] hist;
  } pwo_skew_state_t;

endpackage : pwo_pkg

// >>> pwo_min_pulse.sv
// Minimum pulse stage for one channel.
// Assumes mclkTick pulses once per PWM master clock period on sys_clk.
`timescale 1ns/1ps
module pwo_min_pulse #(
  parameter int MIN_W = 5
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic mclkTick,
  input wire logic [MIN_W-1:0] minCount,
  input wire logic pulseIn,
  output logic pulseOut
);

  pwo_pkg::pwo_min_state_t s;
  pwo_pkg::pwo_min_state_t next_s;

  // Level follows the input only once it has been held long enough
  always_comb
  begin
    next_s = s;
    if (mclkTick)
    begin
      if (s.level != pulseIn && s.held >= minCount)
      begin
        next_s.level = pulseIn;
        next_s.held = 5'h0;
      end
      else if (s.held != {MIN_W{1'b1}})
      begin
        next_s.held = s.held + 5'h1; // Saturates at the top value
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign pulseOut = s.level;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  property p_min_hold;
    $changed(s.level) |-> $past(s.held) >= $past(minCount);
  endproperty
  a_min_hold: assert property (p_min_hold)
    else $error("pulse ended before minimum width");

  property p_no_min;
    mclkTick && minCount == 5'h0 && pulseIn != s.level |=> s.level == $past(pulseIn);
  endproperty
  a_no_min: assert property (p_no_min)
    else $error("zero minimum did not pass edge at once");

endmodule : pwo_min_pulse

// >>> pwo_skew_delay.sv
// Delay line that shifts the minus output of one pair by whole master clock periods.
// Assumes mclkTick pulses once per PWM master clock period on sys_clk.
`timescale 1ns/1ps
module pwo_skew_delay #(
  parameter int SKEW_W = 3,
  parameter int DEPTH = 7
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic mclkTick,
  input wire logic [SKEW_W-1:0] skewCount,
  input wire logic levelIn,
  output logic levelOut
);

  pwo_pkg::pwo_skew_state_t s;
  pwo_pkg::pwo_skew_state_t next_s;

  // History shifts one place per master clock period
  always_comb
  begin
    next_s = s;
    if (mclkTick)
      next_s.hist = {s.hist[DEPTH-2:0], levelIn};
  end

  // State register
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      s <= '0;
    else
      s <= next_s;
  end

  // Zero count passes the level straight through
  assign levelOut = (skewCount == '0) ? levelIn : s.hist[skewCount - 3'h1];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  property p_skew_one;
    mclkTick && skewCount == 3'h1 ##1 $stable(skewCount) && !mclkTick
      |-> levelOut == $past(levelIn);
  endproperty
  a_skew_one: assert property (p_skew_one)
    else $error("one period skew misplaced");

endmodule : pwo_skew_delay

// >>> pwo_output_stage.sv
// Top of the PWM output stage configuration, with an AHB-Lite register slave.
// Assumes pwmIn, mclkTick and modulatorPowerdown come from logic on sys_clk.
`timescale 1ns/1ps
`include "pwo_cfg.svh"
module pwo_output_stage #(
  parameter int CHANNELS = 6,
  parameter int MIN_W = 5,
  parameter int SKEW_W = 3,
  parameter int SKEW_DEPTH = 7
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic modulatorPowerdown,
  input wire logic mclkTick,
  input wire logic [CHANNELS-1:0] pwmIn,
  output logic doubleRateSelect,
  output logic [CHANNELS-1:0] fullBridge,
  output logic [CHANNELS-1:0] outPlus,
  output logic [CHANNELS-1:0] outMinus
);

  pwo_pkg::pwo_top_state_t s;
  pwo_pkg::pwo_top_state_t next_s;
  pwo_pkg::pwo_sel_t addrSel;
  logic addrTaken;
  logic [31:0] readNow;
  logic [CHANNELS-1:0] pulsed;
  logic [CHANNELS-1:0] skewed;
  logic [MIN_W-1:0] minCount;
  logic [SKEW_W-1:0] skewCount;
  logic minusOff;
  logic pending;

  // Address phase is taken on a selected active transfer while the bus is ready
  assign addrTaken = hsel && htrans[`PWO_HTRANS_ACTIVE_BIT] && hready;

  // Address decode of the word-aligned register map
  always_comb
  begin
    if (haddr[`PWO_ADDR_W-1:0] == `PWO_ADDR_OF(`PWO_IDX_RATE_BRIDGE))
      addrSel = pwo_pkg::SEL_RATE_BRIDGE;
    else if (haddr[`PWO_ADDR_W-1:0] == `PWO_ADDR_OF(`PWO_IDX_MIN_PULSE))
      addrSel = pwo_pkg::SEL_MIN_PULSE;
    else if (haddr[`PWO_ADDR_W-1:0] == `PWO_ADDR_OF(`PWO_IDX_OUT_DELAY))
      addrSel = pwo_pkg::SEL_OUT_DELAY;
    else if (haddr[`PWO_ADDR_W-1:0] == `PWO_ADDR_OF(`PWO_IDX_STATUS))
      addrSel = pwo_pkg::SEL_STATUS;
    else
      addrSel = pwo_pkg::SEL_NONE;
  end

  // Settings that software has written but the modulators have not yet taken
  assign pending = (s.shadowCfg != s.activeCfg) || (s.shadowMin != s.activeMin) ||
    (s.shadowDly != s.activeDly);

  // Read data: written settings, or the block's own status; unmapped reads zero
  always_comb
  begin
    readNow = `PWO_RESET_WORD;
    if (addrSel == pwo_pkg::SEL_RATE_BRIDGE)
      readNow[7:0] = s.shadowCfg;
    else if (addrSel == pwo_pkg::SEL_MIN_PULSE)
      readNow[7:0] = s.shadowMin;
    else if (addrSel == pwo_pkg::SEL_OUT_DELAY)
      readNow[7:0] = s.shadowDly;
    else if (addrSel == pwo_pkg::SEL_STATUS)
    begin
      readNow[`PWO_BIT_ST_POWERDOWN] = modulatorPowerdown;
      readNow[`PWO_BIT_ST_REJECTED] = s.rejected;
      readNow[`PWO_BIT_ST_PENDING] = pending;
    end
  end

  // Active settings as seen by the output path
  assign minCount = s.activeMin[`PWO_MIN_MSB:`PWO_MIN_LSB];
  assign skewCount = s.activeDly[`PWO_SKEW_MSB:`PWO_SKEW_LSB];
  assign minusOff = s.activeMin[`PWO_BIT_MINUS_OFF];

  // Bridge mode per channel in order A1, B1, A2, B2, A3, B3
  assign fullBridge[0] = s.activeCfg[`PWO_BIT_PAIR1];
  assign fullBridge[1] = s.activeCfg[`PWO_BIT_PAIR1];
  assign fullBridge[2] = s.activeCfg[`PWO_BIT_PAIR2];
  assign fullBridge[3] = s.activeCfg[`PWO_BIT_PAIR2];
  assign fullBridge[4] = s.activeCfg[`PWO_BIT_A3];
  assign fullBridge[5] = s.activeCfg[`PWO_BIT_B3];

  // Rate select drives the interpolation filter oversampling
  assign doubleRateSelect = s.activeCfg[`PWO_BIT_DOUBLE_RATE];

  // Per-channel pulse shaping: minimum width first, then skew of the minus leg
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_chan
      pwo_min_pulse #(
        .MIN_W(MIN_W)
      ) u_min (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .mclkTick(mclkTick),
        .minCount(minCount),
        .pulseIn(pwmIn[ch]),
        .pulseOut(pulsed[ch])
      );
      pwo_skew_delay #(
        .SKEW_W(SKEW_W),
        .DEPTH(SKEW_DEPTH)
      ) u_skew (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .mclkTick(mclkTick),
        .skewCount(skewCount),
        .levelIn(pulsed[ch]),
        .levelOut(skewed[ch])
      );
    end
  endgenerate

  // Next state: bus phases, guarded writes, settings transfer and output drive
  always_comb
  begin
    next_s = s;
    // Data phase of a write
    if (s.phWrite)
    begin
      if (s.phSel == pwo_pkg::SEL_STATUS && hwdata[`PWO_BIT_ST_REJECTED])
        next_s.rejected = 1'b0;
      if (s.phSel == pwo_pkg::SEL_RATE_BRIDGE)
      begin
        if (modulatorPowerdown)
          next_s.shadowCfg = hwdata[7:0] & `PWO_MASK_RATE_BRIDGE;
        else
          next_s.rejected = 1'b1;
      end
      else if (s.phSel == pwo_pkg::SEL_MIN_PULSE)
      begin
        if (modulatorPowerdown)
          next_s.shadowMin = hwdata[7:0] & `PWO_MASK_MIN_PULSE;
        else
          next_s.rejected = 1'b1;
      end
      else if (s.phSel == pwo_pkg::SEL_OUT_DELAY)
      begin
        if (modulatorPowerdown)
          next_s.shadowDly = hwdata[7:0] & `PWO_MASK_OUT_DELAY;
        else
          next_s.rejected = 1'b1;
      end
    end
    // Address phase capture; read data is latched here for the data phase
    if (addrTaken)
    begin
      next_s.phWrite = hwrite;
      next_s.phSel = addrSel;
      if (!hwrite)
        next_s.rdata = readNow;
    end
    else
    begin
      next_s.phWrite = 1'b0;
      next_s.phSel = pwo_pkg::SEL_NONE;
    end
    // Settings reach the modulators only while they are powered down
    if (modulatorPowerdown)
    begin
      next_s.activeCfg = s.shadowCfg;
      next_s.activeMin = s.shadowMin;
      next_s.activeDly = s.shadowDly;
    end
    // Outputs rest low in power-down; minus leg follows bridge mode
    for (int i = 0; i < CHANNELS; i++)
    begin
      if (modulatorPowerdown)
      begin
        next_s.outPlus[i] = 1'b0;
        next_s.outMinus[i] = 1'b0;
      end
      else
      begin
        next_s.outPlus[i] = pulsed[i];
        if (!fullBridge[i] && minusOff)
          next_s.outMinus[i] = 1'b0;
        else
          next_s.outMinus[i] = ~skewed[i];
      end
    end
  end

  // State register; reset clears every setting
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      s <= '0;
    else
      s <= next_s;
  end

  // Bus answers: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = `PWO_HRESP_OKAY;
  assign hrdata = s.rdata;
  assign outPlus = s.outPlus;
  assign outMinus = s.outMinus;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Write data phase of one settings register
  sequence s_cfg_write;
    s.phWrite && (s.phSel == pwo_pkg::SEL_RATE_BRIDGE ||
      s.phSel == pwo_pkg::SEL_MIN_PULSE || s.phSel == pwo_pkg::SEL_OUT_DELAY);
  endsequence

  property p_locked_write;
    s_cfg_write and !modulatorPowerdown |=>
      $stable(s.shadowCfg) && $stable(s.shadowMin) && $stable(s.shadowDly) && s.rejected;
  endproperty
  a_locked_write: assert property (p_locked_write)
    else $error("settings write taken while modulators run");

  property p_open_write;
    s.phWrite && s.phSel == pwo_pkg::SEL_MIN_PULSE && modulatorPowerdown |=>
      s.shadowMin == ($past(hwdata[7:0]) & `PWO_MASK_MIN_PULSE);
  endproperty
  a_open_write: assert property (p_open_write)
    else $error("settings write lost in power-down");

  property p_running_stable;
    !modulatorPowerdown ##1 !modulatorPowerdown |->
      $stable(s.activeCfg) && $stable(s.activeMin) && $stable(s.activeDly);
  endproperty
  a_running_stable: assert property (p_running_stable)
    else $error("active settings changed while running");

  property p_rate_follow;
    modulatorPowerdown [*2] |-> doubleRateSelect == $past(s.shadowCfg[`PWO_BIT_DOUBLE_RATE]);
  endproperty
  a_rate_follow: assert property (p_rate_follow)
    else $error("rate select does not follow setting");

  property p_pair1;
    modulatorPowerdown [*2] |-> fullBridge[0] == $past(s.shadowCfg[`PWO_BIT_PAIR1]) &&
      fullBridge[1] == fullBridge[0];
  endproperty
  a_pair1: assert property (p_pair1)
    else $error("pair one bridge mode wrong");

  property p_pair2;
    modulatorPowerdown [*2] |-> fullBridge[2] == $past(s.shadowCfg[`PWO_BIT_PAIR2]) &&
      fullBridge[3] == fullBridge[2];
  endproperty
  a_pair2: assert property (p_pair2)
    else $error("pair two bridge mode wrong");

  property p_ch_a3;
    modulatorPowerdown [*2] |-> fullBridge[4] == $past(s.shadowCfg[`PWO_BIT_A3]);
  endproperty
  a_ch_a3: assert property (p_ch_a3)
    else $error("channel A3 bridge mode wrong");

  property p_ch_b3;
    modulatorPowerdown [*2] |-> fullBridge[5] == $past(s.shadowCfg[`PWO_BIT_B3]);
  endproperty
  a_ch_b3: assert property (p_ch_b3)
    else $error("channel B3 bridge mode wrong");

  property p_minus_off;
    !modulatorPowerdown && minusOff && !fullBridge[0] |=> outMinus[0] == 1'b0;
  endproperty
  a_minus_off: assert property (p_minus_off)
    else $error("half-bridge minus output still driven");

  property p_minus_on;
    !modulatorPowerdown && !minusOff && !fullBridge[1] |=> outMinus[1] == ~$past(skewed[1]);
  endproperty
  a_minus_on: assert property (p_minus_on)
    else $error("half-bridge minus output stopped");

  property p_full_keeps;
    !modulatorPowerdown && fullBridge[2] |=> outMinus[2] == ~$past(skewed[2]) &&
      outPlus[2] == $past(pulsed[2]);
  endproperty
  a_full_keeps: assert property (p_full_keeps)
    else $error("full-bridge pair output stopped");

  property p_reset_clear;
    $rose(reset_n) |-> s.shadowCfg == 8'h00 && s.shadowMin == 8'h00 &&
      s.shadowDly == 8'h00 && !doubleRateSelect && fullBridge == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("settings not cleared by reset");

  // Settings transfer and quiet outputs in power-down, rejected flag clearing and read data latching
  property p_skew_load;
    modulatorPowerdown [*2] |-> skewCount == $past(s.shadowDly[`PWO_SKEW_MSB:`PWO_SKEW_LSB]);
  endproperty
  a_skew_load: assert property (p_skew_load)
    else $error("skew setting not loaded in power-down");

  property p_min_load;
    modulatorPowerdown [*2] |-> minCount == $past(s.shadowMin[`PWO_MIN_MSB:`PWO_MIN_LSB]) &&
      minusOff == $past(s.shadowMin[`PWO_BIT_MINUS_OFF]);
  endproperty
  a_min_load: assert property (p_min_load)
    else $error("minimum pulse setting not loaded in power-down");

  property p_quiet_powerdown;
    modulatorPowerdown |=> outPlus == '0 && outMinus == '0;
  endproperty
  a_quiet_powerdown: assert property (p_quiet_powerdown)
    else $error("outputs driven while powered down");

  property p_reject_clear;
    s.phWrite && s.phSel == pwo_pkg::SEL_STATUS && hwdata[`PWO_BIT_ST_REJECTED] |=>
      !s.rejected;
  endproperty
  a_reject_clear: assert property (p_reject_clear)
    else $error("rejected flag not cleared by write");

  property p_read_data;
    addrTaken && !hwrite |=> hrdata == $past(readNow);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read data not latched at address phase");

endmodule : pwo_output_stage

// >>> pwo_stage_model.sv
// Behavioural power stage that watches the six output pairs.
// Assumes the outputs are levels registered on sys_clk.
`timescale 1ns/1ps
module pwo_stage_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [5:0] outPlus,
  input wire logic [5:0] outMinus,
  output logic [47:0] highWidth,
  output logic [7:0] skewLag
);
  logic [47:0] run;
  logic [7:0] lagCnt;
  logic [5:0] prevPlus;
  logic [5:0] prevMinus;
  // Last high pulse length per plus output, and minus lag behind plus on pair 0
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      run <= '0;
      highWidth <= '0;
      skewLag <= '0;
      lagCnt <= '0;
      prevPlus <= '0;
      prevMinus <= '0;
    end
    else
    begin
      prevPlus <= outPlus;
      prevMinus <= outMinus;
      for (int c = 0; c < 6; c++)
      begin
        if (outPlus[c])
          run[8*c +: 8] <= run[8*c +: 8] + 8'h01;
        else
          run[8*c +: 8] <= 8'h00;
        if (prevPlus[c] && !outPlus[c])
          highWidth[8*c +: 8] <= run[8*c +: 8];
      end
      lagCnt <= (outPlus[0] && !prevPlus[0]) ? 8'h01 : lagCnt + 8'h01;
      if (prevMinus[0] && !outMinus[0])
        skewLag <= (outPlus[0] && !prevPlus[0]) ? 8'h00 : lagCnt;
    end
  end
endmodule : pwo_stage_model

// >>> tb_top.sv
// Self-checking bench of the output stage over AHB-Lite with a watching power stage.
// Assumes pwo_cfg.svh on the include path and a master tick every fourth cycle.
`timescale 1ns/1ps
`include "pwo_cfg.svh"
module tb_top;
  logic sys_clk = 0;
  logic reset_n = 0;
  logic hsel = 0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 0;
  logic [31:0] hwdata = '0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic modulatorPowerdown = 1;
  logic mclkTick = 0;
  logic [1:0] tickCnt = '0;
  logic [5:0] pwmIn = '0;
  logic doubleRateSelect;
  logic [5:0] fullBridge;
  logic [5:0] outPlus;
  logic [5:0] outMinus;
  logic [47:0] highWidth;
  logic [7:0] skewLag;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  localparam logic [31:0] A_CFG = {20'h0, `PWO_ADDR_OF(`PWO_IDX_RATE_BRIDGE)};
  localparam logic [31:0] A_MIN = {20'h0, `PWO_ADDR_OF(`PWO_IDX_MIN_PULSE)};
  localparam logic [31:0] A_DLY = {20'h0, `PWO_ADDR_OF(`PWO_IDX_OUT_DELAY)};
  localparam logic [31:0] A_ST = {20'h0, `PWO_ADDR_OF(`PWO_IDX_STATUS)};

  pwo_output_stage pwo_output_stage_i (.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .modulatorPowerdown(modulatorPowerdown), .mclkTick(mclkTick), .pwmIn(pwmIn),
    .doubleRateSelect(doubleRateSelect), .fullBridge(fullBridge), .outPlus(outPlus),
    .outMinus(outMinus));
  pwo_stage_model pwo_stage_model_i (.sys_clk(sys_clk), .reset_n(reset_n), .outPlus(outPlus),
    .outMinus(outMinus), .highWidth(highWidth), .skewLag(skewLag));

  // Clock, master tick every fourth cycle, and hang watchdog
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    tickCnt <= tickCnt + 2'h1;
    mclkTick <= (tickCnt == 2'h3);
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      $display("ERROR watchdog expected finish seen hang");
      conclude();
    end
  end

  // Verdict and end of run
  task automatic conclude();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  // One comparison
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Single AHB-Lite transfer; read data taken at the data phase edge
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0000_0000, {31'h0, hresp});
  endtask : ahb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    ahb(1'b1, a, d, dummy);
  endtask : wr

  task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0000_0000, v);
    chk(what, exp, v);
  endtask : rdchk

  // Settings loaded while powered down, then modulators run
  task automatic setup(input logic [7:0] c, input logic [7:0] m, input logic [7:0] d);
    modulatorPowerdown <= 1'b1;
    wr(A_CFG, {24'h0, c});
    wr(A_MIN, {24'h0, m});
    wr(A_DLY, {24'h0, d});
    @(posedge sys_clk); // Last write must reach the active copy before the run
    modulatorPowerdown <= 1'b0;
    pwmIn <= 6'h00;
    repeat (40) @(posedge sys_clk);
  endtask : setup

  task automatic align();
    do @(posedge sys_clk); while (tickCnt != 2'h3);
  endtask : align

  task automatic test_reset();
    rdchk("cfg reset", A_CFG, 32'h0000_0000);
    rdchk("min reset", A_MIN, 32'h0000_0000);
    rdchk("dly reset", A_DLY, 32'h0000_0000);
    chk("bridge reset", 32'h0000_0000, {26'h0, fullBridge});
    chk("rate reset", 32'h0000_0000, {31'h0, doubleRateSelect});
  endtask : test_reset

  task automatic test_fields();
    logic [7:0] v [5] = '{8'h80, 8'h10, 8'h08, 8'h04, 8'h02};
    logic [5:0] fb [5] = '{6'h00, 6'h03, 6'h0C, 6'h10, 6'h20};
    for (int i = 0; i < 5; i++)
    begin
      wr(A_CFG, {24'h0, v[i]});
      repeat (2) @(posedge sys_clk);
      rdchk("cfg field", A_CFG, {24'h0, v[i]});
      chk("rate", {31'h0, v[i][7]}, {31'h0, doubleRateSelect});
      chk("bridge", {26'h0, fb[i]}, {26'h0, fullBridge});
    end
    wr(A_CFG, 32'h0000_00FF);
    rdchk("cfg reserved", A_CFG, 32'h0000_009E);
    rdchk("unmapped", 32'h0000_0100, 32'h0000_0000);
  endtask : test_fields

  task automatic test_lock();
    setup(8'h00, 8'h00, 8'h00);
    wr(A_CFG, 32'h0000_009E);
    wr(A_MIN, 32'h0000_009F);
    wr(A_DLY, 32'h0000_00E0);
    rdchk("cfg locked", A_CFG, 32'h0000_0000);
    rdchk("min locked", A_MIN, 32'h0000_0000);
    rdchk("dly locked", A_DLY, 32'h0000_0000);
    chk("bridge locked", 32'h0000_0000, {26'h0, fullBridge});
    rdchk("status", A_ST, 32'h0000_0002);
    wr(A_ST, 32'h0000_0002);
    rdchk("status clear", A_ST, 32'h0000_0000);
  endtask : test_lock

  task automatic test_minus();
    setup(8'h14, 8'h80, 8'h00);
    chk("minus off", 32'h0000_0013, {26'h0, outMinus});
    chk("plus low", 32'h0000_0000, {26'h0, outPlus});
    setup(8'h00, 8'h00, 8'h00);
    chk("minus on", 32'h0000_003F, {26'h0, outMinus});
  endtask : test_minus

  task automatic test_min_pulse();
    logic [7:0] w;
    for (int m = 0; m <= 5; m += 5)
    begin
      setup(8'h00, 8'(m), 8'h00);
      align();
      pwmIn <= 6'h3F;
      repeat (4) @(posedge sys_clk);
      pwmIn <= 6'h00;
      repeat (200) @(posedge sys_clk);
      for (int c = 0; c < 6; c++)
      begin
        w = highWidth[8*c +: 8];
        if (m == 0)
          chk("width free", 32'h0000_0004, {24'h0, w});
        else
          chk("width min", 32'h0000_0001, {31'h0, w >= 8'd20});
      end
    end
  endtask : test_min_pulse

  task automatic test_skew();
    logic [2:0] k [3] = '{3'h0, 3'h1, 3'h7};
    for (int i = 0; i < 3; i++)
    begin
      setup(8'h00, 8'h00, {k[i], 5'h00});
      align();
      pwmIn <= 6'h3F;
      repeat (60) @(posedge sys_clk);
      chk("skew lag", {27'h0, k[i], 2'h0}, {24'h0, skewLag});
    end
  endtask : test_skew

  // Main sequence
  initial
  begin
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    test_reset();
    test_fields();
    test_lock();
    test_minus();
    test_min_pulse();
    test_skew();
    conclude();
  end
endmodule : tb_top
